// File: inc/ivu_defs.vh
`ifndef IVU_DEFS_VH
`define IVU_DEFS_VH

// request channels and their fields
`define IVU_NUM_CH       32
`define IVU_CH_IDX_W     5
`define IVU_PRIO_W       4
`define IVU_ADDR_W       32

// channel that carries external_interrupt_three and the merged pin edges
`define IVU_EXT3_CH      5'h11

// edge-capable port pins (two ports together)
`define IVU_NUM_PINS     42

// reset values
`define IVU_RST_STATUS   32'h0000_0000
`define IVU_RST_ADDR     32'h0000_0000
`define IVU_RST_CH       5'h00
`define IVU_RST_PINS     42'h000_0000_0000
`define IVU_RST_FILL     2'h0

// enabled edges after reset before the synchroniser holds real pin levels
`define IVU_SYNC_FILL    2'h3

`endif

// File: verilog/ivu_edge_detect.v
`timescale 1ns/1ps
`include "ivu_defs.vh"

module ivu_edge_detect
(
	// clock and reset
	input  wire                       sys_clk_i,
	input  wire                       resetn_i,
	input  wire                       clk_en_i,
	// pins from outside the clock domain
	input  wire [`IVU_NUM_PINS-1:0]   pin_i,
	// per-pin edge selection
	input  wire [`IVU_NUM_PINS-1:0]   rise_en_i,
	input  wire [`IVU_NUM_PINS-1:0]   fall_en_i,
	// one-cycle clear of captured edges
	input  wire [`IVU_NUM_PINS-1:0]   clear_i,
	// captured edge flags
	output reg  [`IVU_NUM_PINS-1:0]   flag_o
);

	reg  [`IVU_NUM_PINS-1:0]   sync1_reg;
	reg  [`IVU_NUM_PINS-1:0]   sync2_reg;
	reg  [`IVU_NUM_PINS-1:0]   sync3_reg;
	reg  [`IVU_NUM_PINS-1:0]   level_reg;
	reg  [`IVU_NUM_PINS-1:0]   level_next;
	reg  [`IVU_NUM_PINS-1:0]   flag_next;
	wire [`IVU_NUM_PINS-1:0]   rise_w;
	wire [`IVU_NUM_PINS-1:0]   fall_w;
	reg  [1:0]                 fill_reg;
	wire                       primed_w;

	// a change is accepted once the second and third stages agree
	always @*
	begin
		level_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) |
			(level_reg & (sync2_reg ^ sync3_reg));
	end

	// no edges until the level tracker has loaded the real pin level, so an idle-high pin
	// does not look like a rising edge after reset
	assign primed_w = (fill_reg == `IVU_SYNC_FILL);
	assign rise_w   = level_next & ~level_reg & {`IVU_NUM_PINS{primed_w}};
	assign fall_w   = ~level_next & level_reg & {`IVU_NUM_PINS{primed_w}};

	// set wins over clear in the same cycle
	always @*
	begin
		flag_next = (flag_o & ~clear_i) | (rise_w & rise_en_i) | (fall_w & fall_en_i);
	end

	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sync1_reg <= `IVU_RST_PINS;
			sync2_reg <= `IVU_RST_PINS;
			sync3_reg <= `IVU_RST_PINS;
			level_reg <= `IVU_RST_PINS;
			flag_o    <= `IVU_RST_PINS;
			fill_reg  <= `IVU_RST_FILL;
		end
		else if (clk_en_i)
		begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			flag_o    <= flag_next;
			if (primed_w)
			begin
				level_reg <= level_next;
			end
			else
			begin
				level_reg <= sync2_reg;
				fill_reg  <= fill_reg + 2'h1;
			end
		end
	end

endmodule // ivu_edge_detect

// File: verilog/ivu_top.v
// Operation
// - Thirty-two request inputs are accepted and each is placed in the fast or vectored class by its select bit.
// - Fast-class requests outrank every vectored request and never enter vectored arbitration.
// - The fast line is the OR of all enabled requests in the fast class.
// - A status word shows which enabled fast-class sources are requesting, as registered at the last enabled clock edge.
// - Each vectored request has a run-time programmable priority.
// - Among equal-priority vectored requests the lowest-numbered channel wins.
// - The normal line is the OR of all enabled requests in the vectored class.
// - A vector address output gives the service-routine address of the winning vectored request.
// - Each of the 42 port pins may request on a rising edge, a falling edge or both.
// - Pin edge requests are ORed and merged into the external_interrupt_three channel.
`timescale 1ns/1ps
`include "ivu_defs.vh"

module ivu_top
(
	// clock, reset and clock enable
	input  wire                                     sys_clk_i,
	input  wire                                     resetn_i,
	input  wire                                     clk_en_i,
	// peripheral request lines, one per peripheral
	input  wire [`IVU_NUM_CH-1:0]                   irq_req_i,
	// channel configuration
	input  wire [`IVU_NUM_CH-1:0]                   int_enable_i,
	input  wire [`IVU_NUM_CH-1:0]                   fast_select_i,
	input  wire [`IVU_NUM_CH*`IVU_PRIO_W-1:0]       prio_i,
	input  wire [`IVU_NUM_CH*`IVU_ADDR_W-1:0]       vect_addr_i,
	input  wire [`IVU_ADDR_W-1:0]                   default_addr_i,
	// edge-capable port pins
	input  wire [`IVU_NUM_PINS-1:0]                 port_pin_i,
	input  wire [`IVU_NUM_PINS-1:0]                 pin_rise_en_i,
	input  wire [`IVU_NUM_PINS-1:0]                 pin_fall_en_i,
	input  wire [`IVU_NUM_PINS-1:0]                 pin_clear_i,
	// processor core requests
	output reg                                      fast_interrupt_line_o,
	output reg                                      normal_interrupt_line_o,
	// service software view
	output reg  [`IVU_NUM_CH-1:0]                   fast_status_o,
	output reg  [`IVU_ADDR_W-1:0]                   vector_addr_o,
	output reg  [`IVU_CH_IDX_W-1:0]                 vector_channel_o,
	output reg                                      vector_valid_o,
	output reg  [`IVU_NUM_PINS-1:0]                 pin_edge_status_o
);

	wire [`IVU_NUM_PINS-1:0]    pin_flag_w;
	reg  [`IVU_NUM_CH-1:0]      req_merged;
	reg  [`IVU_NUM_CH-1:0]      active;
	reg  [`IVU_NUM_CH-1:0]      fast_act;
	reg  [`IVU_NUM_CH-1:0]      norm_act;
	reg                         found_next;
	reg  [`IVU_CH_IDX_W-1:0]    win_next;
	reg  [`IVU_PRIO_W-1:0]      best_prio;
	reg  [`IVU_ADDR_W-1:0]      addr_next;
	integer                     i;

	// priority field of one channel, 0 is most urgent
	function [`IVU_PRIO_W-1:0] prio_of;
		input [`IVU_NUM_CH*`IVU_PRIO_W-1:0] vec;
		input integer                        ch;
		begin
			prio_of = vec[ch*`IVU_PRIO_W +: `IVU_PRIO_W];
		end
	endfunction

	// service address of one channel
	function [`IVU_ADDR_W-1:0] addr_of;
		input [`IVU_NUM_CH*`IVU_ADDR_W-1:0] vec;
		input [`IVU_CH_IDX_W-1:0]            ch;
		begin
			addr_of = vec[ch*`IVU_ADDR_W +: `IVU_ADDR_W];
		end
	endfunction

	ivu_edge_detect u_edge
	(
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.clk_en_i  (clk_en_i),
		.pin_i     (port_pin_i),
		.rise_en_i (pin_rise_en_i),
		.fall_en_i (pin_fall_en_i),
		.clear_i   (pin_clear_i),
		.flag_o    (pin_flag_w)
	);

	// classify enabled requests
	always @*
	begin
		req_merged = irq_req_i;
		req_merged[`IVU_EXT3_CH] = irq_req_i[`IVU_EXT3_CH] | (|pin_flag_w);
		active   = req_merged & int_enable_i;
		fast_act = active & fast_select_i;
		norm_act = active & ~fast_select_i;
	end

	// vectored arbitration: strict less-than keeps the lowest channel on ties
	always @*
	begin
		found_next = 1'b0;
		win_next   = `IVU_RST_CH;
		best_prio  = {`IVU_PRIO_W{1'b1}};
		for (i = 0; i < `IVU_NUM_CH; i = i + 1)
		begin
			if (norm_act[i] && (!found_next || prio_of(prio_i, i) < best_prio))
			begin
				found_next = 1'b1;
				win_next   = i[`IVU_CH_IDX_W-1:0];
				best_prio  = prio_of(prio_i, i);
			end
		end
		if (found_next)
		begin
			addr_next = addr_of(vect_addr_i, win_next);
		end
		else
		begin
			addr_next = default_addr_i;
		end
	end

	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fast_interrupt_line_o   <= 1'b0;
			normal_interrupt_line_o <= 1'b0;
			fast_status_o           <= `IVU_RST_STATUS;
			vector_addr_o           <= `IVU_RST_ADDR;
			vector_channel_o        <= `IVU_RST_CH;
			vector_valid_o          <= 1'b0;
			pin_edge_status_o       <= `IVU_RST_PINS;
		end
		else if (clk_en_i)
		begin
			fast_interrupt_line_o   <= |fast_act;
			normal_interrupt_line_o <= |norm_act;
			fast_status_o           <= fast_act;
			vector_addr_o           <= addr_next;
			vector_channel_o        <= win_next;
			vector_valid_o          <= found_next;
			pin_edge_status_o       <= pin_flag_w;
		end
	end

endmodule // ivu_top

// File: bench/ivu_core_model.sv
`timescale 1ns/1ps
// core side: a fast request is taken ahead of any normal request
module ivu_core_model
(
	input  wire       sys_clk_i,
	input  wire       resetn_i,
	input  wire       fast_interrupt_line_o,
	input  wire       normal_interrupt_line_o,
	output reg  [1:0] taken_o
);
	always @(posedge sys_clk_i or negedge resetn_i)
		if (!resetn_i) taken_o <= 2'h0;
		else if (fast_interrupt_line_o) taken_o <= 2'h1;
		else if (normal_interrupt_line_o) taken_o <= 2'h2;
		else taken_o <= 2'h0;
endmodule // ivu_core_model

// File: bench/ivu_top_properties.sv
`timescale 1ns/1ps
module ivu_props
(
	input wire          sys_clk_i, resetn_i, clk_en_i,
	input wire [31:0]   irq_req_i, int_enable_i, fast_select_i, default_addr_i,
	input wire [1023:0] vect_addr_i,
	input wire          fast_interrupt_line_o, normal_interrupt_line_o, vector_valid_o,
	input wire [31:0]   fast_status_o, vector_addr_o,
	input wire [4:0]    vector_channel_o
);
	wire [31:0] fq = irq_req_i & int_enable_i & fast_select_i;
	wire [31:0] nq = irq_req_i & int_enable_i & ~fast_select_i;
	reg         ok = 1'b0;
	// previous edge was out of reset and enabled
	always @(posedge sys_clk_i) ok <= resetn_i && clk_en_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	property p_fast; clk_en_i && |fq |=> fast_interrupt_line_o; endproperty
	property p_stat; clk_en_i |=> (fast_status_o & 32'hfffd_ffff) == $past(fq & 32'hfffd_ffff);
	endproperty
	property p_norm; clk_en_i && |nq |=> normal_interrupt_line_o && vector_valid_o; endproperty
	property p_dis; clk_en_i |=> (fast_status_o & ~$past(int_enable_i)) == 32'h0000_0000;
	endproperty
	property p_cls; ok && vector_valid_o |-> !(($past(fast_select_i) >> vector_channel_o) & 1);
	endproperty
	property p_addr;
		ok && vector_valid_o |-> vector_addr_o == 32'(($past(vect_addr_i) >> (32 * vector_channel_o)));
	endproperty
	property p_dflt; ok && !vector_valid_o |-> vector_addr_o == $past(default_addr_i); endproperty
	property p_ch0; !vector_valid_o |-> vector_channel_o == 5'h00; endproperty
	a_fast: assert property (p_fast) else $error("fast line missing");
	a_stat: assert property (p_stat) else $error("fast status wrong");
	a_norm: assert property (p_norm) else $error("normal line missing");
	a_dis: assert property (p_dis) else $error("disabled source seen");
	a_cls: assert property (p_cls) else $error("fast source in vector");
	a_addr: assert property (p_addr) else $error("vector address wrong");
	a_dflt: assert property (p_dflt) else $error("default address wrong");
	a_ch0: assert property (p_ch0) else $error("idle channel not zero");
	c_fast: cover property (fast_interrupt_line_o);
	c_norm: cover property (normal_interrupt_line_o && vector_channel_o == 5'h03);
	c_pin: cover property (vector_valid_o && vector_channel_o == 5'h11);
endmodule // ivu_props
bind ivu_top ivu_props i_props (.*);

// File: bench/vectored_interrupt_controller_tb.sv
`timescale 1ns/1ps
module vectored_interrupt_controller_tb;
	reg          sys_clk_i = 0, resetn_i = 0, clk_en_i = 1;
	// one request line per peripheral channel
	reg  [31:0]  irq_req_i = 0, int_enable_i = 0, fast_select_i = 0, default_addr_i = 32'h0000_0f00;
	reg  [127:0] prio_i = {32{4'hf}};
	reg  [1023:0] vect_addr_i;
	reg  [41:0]  port_pin_i = 0, pin_rise_en_i = 0, pin_fall_en_i = 0, pin_clear_i = 0;
	wire         fast_interrupt_line_o, normal_interrupt_line_o, vector_valid_o;
	wire [31:0]  fast_status_o, vector_addr_o;
	wire [4:0]   vector_channel_o;
	wire [41:0]  pin_edge_status_o;
	wire [1:0]   taken_o;
	integer      errors = 0, total_checks = 0, i;
	ivu_top i_dut (.*);
	ivu_core_model i_core (.*);
	initial for (i = 0; i < 32; i = i + 1) vect_addr_i[i*32 +: 32] = 32'h1000_0000 + i * 16;
	initial forever #5 sys_clk_i = ~sys_clk_i;
	task summarize;
		begin
			if (errors == 0 && total_checks > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	task chk(input [63:0] s, input [63:0] e);
		begin
			total_checks = total_checks + 1;
			if (s !== e)
			begin
				errors = errors + 1;
				$display("[ERR] %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task step; begin @(posedge sys_clk_i); #1; end endtask
	task wait_vec(input [41:0] st);
		begin
			i = 0;
			while (!(vector_valid_o === 1'b1 && pin_edge_status_o === st) && i < 12)
			begin step; i = i + 1; end
			if (i >= 12) begin errors = errors + 1; summarize; end
			chk(vector_channel_o, 5'h11);
		end
	endtask
	task t_fast;
		begin
			@(posedge sys_clk_i);
			int_enable_i <= 32'h4000_0004; fast_select_i <= 32'h4000_0004; irq_req_i <= 32'h4000_0004;
			step; chk(fast_interrupt_line_o, 1); chk(fast_status_o, 32'h4000_0004);
			chk(vector_valid_o, 0); step; chk(taken_o, 2'h1);
			fast_select_i <= 32'h0000_0004;
			step; chk(normal_interrupt_line_o, 1); chk(vector_channel_o, 5'h1e);
			chk(fast_status_o, 32'h0000_0004); step; chk(taken_o, 2'h1);
		end
	endtask
	task t_prio;
		begin
			@(posedge sys_clk_i);
			irq_req_i <= 32'h0000_010a; int_enable_i <= 32'h0000_0108; fast_select_i <= 0;
			prio_i[12 +: 4] <= 4'h5; prio_i[32 +: 4] <= 4'h2; prio_i[4 +: 4] <= 4'h0;
			step; chk(vector_channel_o, 5'h08); chk(vector_addr_o, vect_addr_i[256 +: 32]);
			prio_i[12 +: 4] <= 4'h2;
			step; chk(vector_channel_o, 5'h03); chk(vector_addr_o, vect_addr_i[96 +: 32]);
			int_enable_i <= 0;
			step; chk(vector_valid_o, 0); chk(vector_addr_o, default_addr_i);
			chk(normal_interrupt_line_o, 0);
		end
	endtask
	task t_hold;
		begin
			@(posedge sys_clk_i);
			clk_en_i <= 0; int_enable_i <= 32'h0000_0008;
			step; chk(normal_interrupt_line_o, 0); chk(vector_valid_o, 0);
			clk_en_i <= 1;
			step; chk(normal_interrupt_line_o, 1); chk(vector_channel_o, 5'h03);
		end
	endtask
	task t_pin;
		begin
			@(posedge sys_clk_i);
			irq_req_i <= 0; int_enable_i <= 32'h0002_0000; pin_rise_en_i <= 42'h1;
			step; port_pin_i <= 42'h1;
			wait_vec(42'h1);
			pin_clear_i <= 42'h1; step; pin_clear_i <= 0; pin_fall_en_i <= 42'h1;
			repeat (3) step; chk(vector_valid_o, 0); chk(pin_edge_status_o, 0);
			port_pin_i <= 42'h0;
			wait_vec(42'h1);
		end
	endtask
	initial
	begin
		repeat (6) @(posedge sys_clk_i);
		resetn_i <= 1;
		t_fast; t_prio; t_hold; t_pin;
		summarize;
	end
endmodule // vectored_interrupt_controller_tb
